// ---- exec_pkg.sv ----
// Shared constants, opcodes and carrier types of the skip/subtract/xor unit.
`default_nettype none
package exec_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned PC_W   = 12;

    // Register offsets (byte addresses) of the APB register file.
    localparam logic [11:0] OFF_INSTR  = 12'h000;
    localparam logic [11:0] OFF_OPER   = 12'h004;
    localparam logic [11:0] OFF_WORK   = 12'h008;
    localparam logic [11:0] OFF_FLAGS  = 12'h00c;
    localparam logic [11:0] OFF_TPTR   = 12'h010;
    localparam logic [11:0] OFF_THIGH  = 12'h014;
    localparam logic [11:0] OFF_STATUS = 12'h018;
    localparam logic [11:0] OFF_RESULT = 12'h01c;

    // Field positions.
    localparam int unsigned FLG_C_POS  = 0;
    localparam int unsigned FLG_AC_POS = 1;
    localparam int unsigned FLG_Z_POS  = 2;
    localparam int unsigned FLG_OV_POS = 3;
    localparam int unsigned INS_OP_LSB = 0;
    localparam int unsigned INS_BIT_LSB = 8;
    localparam int unsigned INS_IMM_LSB = 16;

    // Reset values.
    localparam logic [7:0]  WORK_RST  = 8'h00;
    localparam logic [3:0]  FLAGS_RST = 4'h0;
    localparam logic [7:0]  TPTR_RST  = 8'h00;
    localparam logic [7:0]  THIGH_RST = 8'h00;

    // Timing counts in instruction cycles.
    localparam int unsigned SKIP_CYCLES = 2;

    typedef enum logic [4:0] {
        OP_NONE                 = 5'h00,
        OP_INCR_SKIP_IF_ZERO    = 5'h01,
        OP_INCR_TO_WORK_SKIP    = 5'h02,
        OP_SKIP_IF_BIT_SET      = 5'h03,
        OP_SUBTRACT             = 5'h04,
        OP_SUBTRACT_TO_MEMORY   = 5'h05,
        OP_SUBTRACT_IMMEDIATE   = 5'h06,
        OP_NIBBLE_EXCHANGE      = 5'h07,
        OP_NIBBLE_EXCHANGE_WORK = 5'h08,
        OP_SKIP_IF_NULL         = 5'h09,
        OP_MOVE_AND_SKIP_NULL   = 5'h0a,
        OP_SKIP_IF_BIT_CLEAR    = 5'h0b,
        OP_TABLE_READ_CURRENT   = 5'h0c,
        OP_TABLE_READ_LAST      = 5'h0d,
        OP_EXCLUSIVE_OR         = 5'h0e,
        OP_EXCLUSIVE_OR_TO_MEM  = 5'h0f,
        OP_EXCLUSIVE_OR_IMM     = 5'h10
    } op_e;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_EXEC  = 3'b010,
        ST_DUMMY = 3'b100
    } state_e;

    typedef struct packed {
        logic       arith_excess_flag;
        logic       zero;
        logic       half_carry_flag;
        logic       carry;
    } flags_s;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } mem_wr_s;

    typedef struct packed {
        logic        prdy;
        logic [31:0] prdata;
        logic        pslverr;
    } apb_rsp_s;

endpackage : exec_pkg
`default_nettype wire

// ---- exec_unit.sv ----
// Execution unit for skip, subtract, nibble swap, table read and xor.
`timescale 1ns/1ps
`default_nettype none
module exec_unit
    import exec_pkg::*;
#(
    parameter int unsigned PAGE_BITS = 4
) (
    input  wire logic        pclk,          // Core clock, 20 MHz.
    input  wire logic        presetn,       // Asynchronous reset, active low.
    input  wire logic        psel,          // APB select.
    input  wire logic        penable,       // APB access phase.
    input  wire logic        pwrite,        // APB write.
    input  wire logic [11:0] paddr,         // APB byte address.
    input  wire logic [31:0] pwdata,        // APB write data.
    input  wire logic [3:0]  pstrb,         // APB byte strobes.
    output logic             pready,        // APB ready.
    output logic [31:0]      prdata,        // APB read data.
    output logic             pslverr,       // APB error on unmapped address.
    input  wire logic [7:0]  mem_rdata,     // Data memory byte at mem_addr.
    input  wire logic [15:0] prog_word,     // Program word at prog_addr.
    output logic [7:0]       mem_addr,      // Data memory address.
    output logic             mem_wr,        // Data memory write pulse.
    output logic [7:0]       mem_wdata,     // Data memory write data.
    output logic [11:0]      prog_addr      // Program memory address.
);

    localparam int unsigned PC_OFF_W = PC_W - PAGE_BITS;

    typedef struct packed {
        state_e      st;
        logic [4:0]  op;
        logic [2:0]  bsel;
        logic [7:0]  imm;
        logic [7:0]  oper;
        logic [7:0]  work;
        flags_s      flg;
        logic [7:0]  tptr;
        logic [7:0]  thigh;
        logic [PAGE_BITS-1:0] page;
        logic        busy;
        logic        skipped;
        logic [7:0]  result;
        mem_wr_s     mw;
        logic [11:0] paddr_o;
        apb_rsp_s    rsp;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic        wr_acc;
    logic        rd_acc;
    logic        mapped;
    logic [8:0]  diff;
    logic [4:0]  hdiff;
    logic [7:0]  sub_b;
    logic [7:0]  res;
    logic        skip;
    logic [31:0] rdv;

    always_comb begin
        s_d       = s_q;
        diff      = 9'h000;
        hdiff     = 5'h00;
        sub_b     = 8'h00;
        res       = 8'h00;
        skip      = 1'b0;
        rdv       = 32'h0000_0000;
        wr_acc    = psel && penable && pwrite && !s_q.rsp.prdy;
        rd_acc    = psel && penable && !pwrite && !s_q.rsp.prdy;
        mapped    = (paddr[1:0] == 2'b00) && (paddr <= OFF_RESULT);
        s_d.mw.wr = 1'b0;

        // Access takes one wait state; pready pulses on the second cycle.
        s_d.rsp.prdy    = psel && penable && !s_q.rsp.prdy;
        s_d.rsp.pslverr = (wr_acc || rd_acc) && !mapped;
        case (paddr)
            OFF_INSTR:  rdv = {8'h00, s_q.imm, 5'h00, s_q.bsel, 3'h0, s_q.op};
            OFF_OPER:   rdv = {24'h000000, s_q.oper};
            OFF_WORK:   rdv = {24'h000000, s_q.work};
            OFF_FLAGS:  rdv = {28'h0000000, s_q.flg};
            OFF_TPTR:   rdv = {24'h000000, s_q.tptr};
            OFF_THIGH:  rdv = {24'h000000, s_q.thigh};
            OFF_STATUS: rdv = {29'h0, s_q.skipped, s_q.busy, 1'b0};
            OFF_RESULT: rdv = {24'h000000, s_q.result};
            default:    rdv = 32'h0000_0000;
        endcase
        s_d.rsp.prdata = rd_acc ? rdv : 32'h0000_0000;

        // Writes while an instruction runs are dropped except reading.
        if (wr_acc && mapped && !s_q.busy && pstrb[0]) begin
            case (paddr)
                OFF_INSTR: begin
                    s_d.op   = pwdata[INS_OP_LSB +: 5];
                    s_d.bsel = pwdata[INS_BIT_LSB +: 3];
                    s_d.imm  = pwdata[INS_IMM_LSB +: 8];
                    s_d.busy = 1'b1;
                    s_d.st   = ST_EXEC;
                    s_d.paddr_o = {s_q.page,
                                   s_q.tptr[PC_OFF_W-1:0]};
                end
                OFF_OPER:  s_d.oper  = pwdata[7:0];
                OFF_WORK:  s_d.work  = pwdata[7:0];
                OFF_FLAGS: s_d.flg   = pwdata[3:0];
                OFF_TPTR:  s_d.tptr  = pwdata[7:0];
                OFF_THIGH: s_d.page  = pwdata[PAGE_BITS-1:0];
                default:   s_d.oper  = s_q.oper;
            endcase
        end

        case (s_q.st)
            ST_IDLE: begin
                s_d.mw.addr = s_q.oper;
            end
            ST_EXEC: begin
                s_d.skipped = 1'b0;
                s_d.st      = ST_IDLE;
                s_d.busy    = 1'b0;
                sub_b = (s_q.op == OP_SUBTRACT_IMMEDIATE) ? s_q.imm : mem_rdata;
                diff  = {1'b0, s_q.work} - {1'b0, sub_b};
                hdiff = {1'b0, s_q.work[3:0]} - {1'b0, sub_b[3:0]};
                case (s_q.op)
                    OP_INCR_SKIP_IF_ZERO: begin
                        res  = mem_rdata + 8'h01;
                        s_d.mw = '{wr: 1'b1, addr: s_q.oper, data: res};
                        skip = (res == 8'h00);
                    end
                    OP_INCR_TO_WORK_SKIP: begin
                        res      = mem_rdata + 8'h01;
                        s_d.work = res;
                        skip     = (res == 8'h00);
                    end
                    OP_SKIP_IF_BIT_SET: skip = mem_rdata[s_q.bsel];
                    OP_SKIP_IF_BIT_CLEAR: skip = !mem_rdata[s_q.bsel];
                    OP_SKIP_IF_NULL: skip = (mem_rdata == 8'h00);
                    OP_MOVE_AND_SKIP_NULL: begin
                        res      = mem_rdata;
                        s_d.work = res;
                        skip     = (res == 8'h00);
                    end
                    OP_SUBTRACT, OP_SUBTRACT_TO_MEMORY,
                    OP_SUBTRACT_IMMEDIATE: begin
                        res = diff[7:0];
                        if (s_q.op == OP_SUBTRACT_TO_MEMORY) begin
                            s_d.mw = '{wr: 1'b1, addr: s_q.oper, data: res};
                        end else begin
                            s_d.work = res;
                        end
                        s_d.flg.carry = !diff[8];
                        s_d.flg.half_carry_flag = !hdiff[4];
                        s_d.flg.zero = (res == 8'h00);
                        s_d.flg.arith_excess_flag =
                            (s_q.work[7] != sub_b[7]) &&
                            (res[7] != s_q.work[7]);
                    end
                    OP_NIBBLE_EXCHANGE: begin
                        res = {mem_rdata[3:0], mem_rdata[7:4]};
                        s_d.mw = '{wr: 1'b1, addr: s_q.oper, data: res};
                    end
                    OP_NIBBLE_EXCHANGE_WORK: begin
                        res      = {mem_rdata[3:0], mem_rdata[7:4]};
                        s_d.work = res;
                    end
                    OP_TABLE_READ_CURRENT, OP_TABLE_READ_LAST: begin
                        res       = prog_word[7:0];
                        s_d.mw    = '{wr: 1'b1, addr: s_q.oper, data: res};
                        s_d.thigh = prog_word[15:8];
                    end
                    OP_EXCLUSIVE_OR, OP_EXCLUSIVE_OR_IMM: begin
                        res = s_q.work ^ ((s_q.op == OP_EXCLUSIVE_OR_IMM)
                                          ? s_q.imm : mem_rdata);
                        s_d.work     = res;
                        s_d.flg.zero = (res == 8'h00);
                    end
                    OP_EXCLUSIVE_OR_TO_MEM: begin
                        res = s_q.work ^ mem_rdata;
                        s_d.mw = '{wr: 1'b1, addr: s_q.oper, data: res};
                        s_d.flg.zero = (res == 8'h00);
                    end
                    default: res = 8'h00;
                endcase
                s_d.result = res;
                // Only skips take the extra cycle; flags elsewhere hold.
                if (skip) begin
                    s_d.st      = ST_DUMMY;
                    s_d.busy    = 1'b1;
                    s_d.skipped = 1'b1;
                end
            end
            ST_DUMMY: begin
                s_d.st   = ST_IDLE;
                s_d.busy = 1'b0;
            end
            default: s_d.st = ST_IDLE;
        endcase

        // Last-page read overrides the page bits; the pointer stays put.
        if (s_d.st == ST_EXEC && s_d.op == OP_TABLE_READ_LAST) begin
            s_d.paddr_o = {{PAGE_BITS{1'b1}},
                           s_q.tptr[PC_OFF_W-1:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{st: ST_IDLE, op: 5'h00, bsel: 3'h0, imm: 8'h00,
                     oper: 8'h00, work: WORK_RST, flg: FLAGS_RST,
                     tptr: TPTR_RST, thigh: THIGH_RST, page: '0,
                     busy: 1'b0, skipped: 1'b0, result: 8'h00,
                     mw: '0, paddr_o: 12'h000, rsp: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign pready    = s_q.rsp.prdy;
    assign prdata    = s_q.rsp.prdata;
    assign pslverr   = s_q.rsp.pslverr;
    assign mem_addr  = s_q.mw.addr;
    assign mem_wr    = s_q.mw.wr;
    assign mem_wdata = s_q.mw.data;
    assign prog_addr = s_q.paddr_o;

endmodule : exec_unit
`default_nettype wire

// ---- exec_unit_sva.sv ----
// Port-level assertions for the execution unit.
`timescale 1ns/1ps
`default_nettype none
module exec_unit_sva
    import exec_pkg::*;
(
    input wire logic        pclk,     // Core clock.
    input wire logic        presetn,  // Reset, active low.
    input wire logic        psel,     // APB select.
    input wire logic        penable,  // APB access phase.
    input wire logic        pwrite,   // APB write.
    input wire logic [11:0] paddr,    // APB byte address.
    input wire logic        pready,   // APB ready.
    input wire logic [31:0] prdata,   // APB read data.
    input wire logic        pslverr,  // APB error.
    input wire logic [7:0]  mem_addr, // Data memory address.
    input wire logic        mem_wr    // Data memory write pulse.
);
    logic [2:0] since_q;

    // Saturates so that a stray write long after any instruction is caught.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            since_q <= 3'h7;
        else if (psel && penable && pwrite && paddr == OFF_INSTR)
            since_q <= 3'h0;
        else if (since_q != 3'h7)
            since_q <= since_q + 3'h1;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    wait_state_a: assert property (psel && $rose(penable) |=> pready)
        else $error("pready not one cycle after access");
    error_map_a: assert property (pready && paddr > OFF_RESULT |-> pslverr)
        else $error("unmapped access without pslverr");
    idle_data_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside ready");
    write_cause_a: assert property (mem_wr |-> since_q < 3'h4)
        else $error("memory write without a recent instruction");
    write_pulse_a: assert property (mem_wr |=> !mem_wr)
        else $error("memory write longer than one cycle");
    write_addr_a: assert property (mem_wr |-> $stable(mem_addr))
        else $error("memory address moved during write");
    reset_quiet_a: assert property ($rose(presetn) |-> !pready && !mem_wr)
        else $error("outputs active right after reset");
endmodule : exec_unit_sva
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the execution unit.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import exec_pkg::*;
    typedef struct packed {logic e; logic [31:0] m; logic [31:0] v;} exp_s;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, pready, pslverr, mem_wr;
    logic [11:0] paddr = 12'h000, prog_addr;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0]  pstrb = 4'hf;
    logic [7:0]  mem_addr, mem_wdata, mem_rdata, mem_q [256];
    logic [15:0] prog_word;
    exp_s        notes_q [$], e;
    int          miscompares = 0, samples_checked = 0, cycles = 0;

    always #25 pclk = ~pclk;
    // Word tells its own address so table reads can be predicted.
    assign prog_word = {prog_addr[11:4], prog_addr[7:0] ^ 8'h3c};
    assign mem_rdata = mem_q[mem_addr];
    always @(posedge pclk) if (mem_wr) mem_q[mem_addr] <= mem_wdata;

    exec_unit dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .pready, .prdata, .pslverr, .mem_rdata, .prog_word,
        .mem_addr, .mem_wr, .mem_wdata, .prog_addr);

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    task automatic chk(string what, logic [31:0] x, logic [31:0] got);
        samples_checked++;
        if (got !== x) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, x, got);
        end
    endtask : chk

    always @(posedge pclk) begin
        cycles++;
        if (cycles > 20000) begin
            miscompares++;
            end_of_test();
        end
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = notes_q.pop_front();
            chk("prdata", e.v, prdata & e.m);
            chk("pslverr", {31'h0, e.e}, {31'h0, pslverr});
        end
    end

    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(logic [11:0] a, logic [31:0] m, logic [31:0] v, logic r);
        notes_q.push_back('{r, m, v});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic run(op_e op, int i);
        logic [7:0] a, m, x, s, r, na, nm, th;
        logic [3:0] f, nf, pg;
        logic [2:0] b;
        logic       sk;
        logic [8:0] d;
        a = 8'($urandom);
        m = (i % 3 == 0) ? 8'hff : (i % 3 == 1) ? 8'h00 : 8'($urandom);
        x = 8'($urandom);
        f = 4'($urandom);
        b = 3'($urandom);
        pg = 4'($urandom);
        mem_q[8'(i)] <= m;
        apb(1'b1, OFF_WORK, {24'h0, a});
        apb(1'b1, OFF_FLAGS, {28'h0, f});
        apb(1'b1, OFF_OPER, 32'(i));
        apb(1'b1, OFF_TPTR, {24'h0, x});
        apb(1'b1, OFF_THIGH, {28'h0, pg});
        s = (op == OP_SUBTRACT_IMMEDIATE) ? x : m;
        d = {1'b0, a} - {1'b0, s};
        r = a ^ ((op == OP_EXCLUSIVE_OR_IMM) ? x : m);
        nf = f;
        case (op)
            OP_INCR_SKIP_IF_ZERO, OP_INCR_TO_WORK_SKIP: sk = m == 8'hff;
            OP_SKIP_IF_BIT_SET: sk = m[b];
            OP_SKIP_IF_BIT_CLEAR: sk = !m[b];
            OP_SKIP_IF_NULL, OP_MOVE_AND_SKIP_NULL: sk = m == 8'h00;
            default: sk = 1'b0;
        endcase
        case (op)
            OP_INCR_TO_WORK_SKIP: na = m + 8'h1;
            OP_SUBTRACT, OP_SUBTRACT_IMMEDIATE: na = d[7:0];
            OP_NIBBLE_EXCHANGE_WORK: na = {m[3:0], m[7:4]};
            OP_MOVE_AND_SKIP_NULL: na = m;
            OP_EXCLUSIVE_OR, OP_EXCLUSIVE_OR_IMM: na = r;
            default: na = a;
        endcase
        case (op)
            OP_INCR_SKIP_IF_ZERO: nm = m + 8'h1;
            OP_SUBTRACT_TO_MEMORY: nm = d[7:0];
            OP_NIBBLE_EXCHANGE: nm = {m[3:0], m[7:4]};
            OP_TABLE_READ_CURRENT, OP_TABLE_READ_LAST: nm = x ^ 8'h3c;
            OP_EXCLUSIVE_OR_TO_MEM: nm = r;
            default: nm = m;
        endcase
        if (op inside {OP_SUBTRACT, OP_SUBTRACT_TO_MEMORY, OP_SUBTRACT_IMMEDIATE})
            nf = {(a[7] != s[7]) && (d[7] != a[7]), d[7:0] == 8'h0,
                  a[3:0] >= s[3:0], !d[8]};
        if (op inside {OP_EXCLUSIVE_OR, OP_EXCLUSIVE_OR_TO_MEM, OP_EXCLUSIVE_OR_IMM})
            nf[2] = r == 8'h0;
        th = {(op == OP_TABLE_READ_LAST) ? 4'hf : pg, x[7:4]};
        apb(1'b1, OFF_INSTR, {8'h0, x, 5'h0, b, 3'h0, op});
        rd(OFF_WORK, 32'hff, {24'h0, na}, 1'b0);
        rd(OFF_FLAGS, 32'hf, {28'h0, nf}, 1'b0);
        rd(OFF_STATUS, 32'h6, {29'h0, sk, 2'h0}, 1'b0);
        if (op inside {OP_TABLE_READ_CURRENT, OP_TABLE_READ_LAST})
            rd(OFF_THIGH, 32'hff, {24'h0, th}, 1'b0);
        if (op inside {OP_EXCLUSIVE_OR, OP_EXCLUSIVE_OR_TO_MEM,
                       OP_EXCLUSIVE_OR_IMM})
            rd(OFF_RESULT, 32'hff, {24'h0, r}, 1'b0);
        chk("memory byte", {24'h0, nm}, {24'h0, mem_q[8'(i)]});
    endtask : run

    initial begin
        void'($urandom(33));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_WORK, 32'hff, {24'h0, WORK_RST}, 1'b0);
        rd(OFF_FLAGS, 32'hf, {28'h0, FLAGS_RST}, 1'b0);
        pstrb <= 4'h0;
        apb(1'b1, OFF_WORK, 32'h5a);
        pstrb <= 4'hf;
        rd(OFF_WORK, 32'hff, {24'h0, WORK_RST}, 1'b0);
        rd(12'h020, 32'h0, 32'h0, 1'b1);
        rd(12'h002, 32'h0, 32'h0, 1'b1);
        $display("test reset_and_map done");
        for (int i = 0; i < 51; i++)
            run(op_e'(i % 16 + 1), i);
        $display("test opcodes done");
        end_of_test();
    end
endmodule : tb_top

bind exec_unit exec_unit_sva chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pready, .prdata, .pslverr, .mem_addr, .mem_wr);
`default_nettype wire
